// File: logic/aacs_pkg.sv
// Constants for the auxiliary converter calibration and step-zero configuration block.
// Assumes a 32-bit AXI4-Lite master; register indices map to byte address index * 4.
package aacs_pkg;

    // ******************************************************
    // Bus geometry
    // ******************************************************
    localparam int unsigned AXI_ADDR_W = 12;
    localparam int unsigned AXI_DATA_W = 32;

    // ******************************************************
    // Register indices and byte addresses
    // ******************************************************
    localparam logic [9:0]  AUX_OFFSET_CORRECTION_IDX     = 10'h08e;
    localparam logic [9:0]  AUX_GAIN_CORRECTION_IDX       = 10'h08f;
    localparam logic [9:0]  SEQUENCE_STEP_ZERO_CONFIG_IDX = 10'h090;
    localparam logic [11:0] AUX_OFFSET_CORRECTION_ADDR    = {AUX_OFFSET_CORRECTION_IDX, 2'b00};
    localparam logic [11:0] AUX_GAIN_CORRECTION_ADDR      = {AUX_GAIN_CORRECTION_IDX, 2'b00};
    localparam logic [11:0] SEQUENCE_STEP_ZERO_CONFIG_ADDR =
        {SEQUENCE_STEP_ZERO_CONFIG_IDX, 2'b00};
    localparam logic [11:0] AUX_SEQUENCE_CONTROL_ADDR     = 12'h300;
    localparam logic [11:0] AUX_RESULT_STATUS_ADDR        = 12'h304;

    // ******************************************************
    // Reset values
    // ******************************************************
    localparam logic [15:0] AUX_OFFSET_CORRECTION_RST     = 16'h0000;
    localparam logic [15:0] AUX_GAIN_CORRECTION_RST       = 16'h0000;
    localparam logic [15:0] SEQUENCE_STEP_ZERO_CONFIG_RST = 16'h0000;

    // ******************************************************
    // Step-zero configuration fields
    // ******************************************************
    localparam int unsigned STEP_ENABLE_BIT   = 15;
    localparam int unsigned STEP_GAIN_MSB     = 14;
    localparam int unsigned STEP_GAIN_LSB     = 13;
    localparam int unsigned STEP_NEG_BIT      = 4;
    localparam int unsigned STEP_POS_MSB      = 3;
    localparam logic [15:0] STEP_CFG_WMASK    = 16'he01f;
    localparam int unsigned SEQ_START_BIT     = 0;

    // Gain codes and the gain values they select
    localparam logic [1:0] GAIN_CODE_1 = 2'b00;
    localparam logic [1:0] GAIN_CODE_2 = 2'b01;
    localparam logic [2:0] GAIN_VAL_1  = 3'h1;
    localparam logic [2:0] GAIN_VAL_2  = 3'h2;
    localparam logic [2:0] GAIN_VAL_4  = 3'h4;

    // Positive-select codes from here upward choose the negative input themselves
    localparam logic [3:0] POS_AUTO_NEG_FIRST = 4'h8;

    // Gain correction scaling: one plus code over two to the sixteen
    localparam int unsigned GCAL_FRAC_BITS = 16;

    // ******************************************************
    // AXI responses
    // ******************************************************
    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

endpackage : aacs_pkg

// File: logic/aacs_top.sv
// AXI4-Lite register block with offset and gain correction of the auxiliary converter
// results and the step-zero configuration outputs for the sequencer.
// Assumes raw results arrive on aclk from the converter; the sequencer engine lies outside.
// Functional notes
// R1: Offset word is signed two's complement and is added to every converter result.
// R2: Offset count weighs one result count at gain 1, half a count at gain 2 or 4.
// R3: Gain word is signed; result is multiplied by one plus code over 65536.
// R4: Bit 15 enables step zero; a disabled step is not converted.
// R5: Bits 14:13 set step-zero gain: 00 is 1, 01 is 2, 10 and 11 are 4.
// R6: Bit 4 selects negative input: analog ground or external input seven.
// R7: Bits 3:0 select positive input; codes 0 to 7 pick external inputs 0 to 7.
// R8: Codes 8 up route temperature sensor, ground short, test DAC, supplies.
// R9: For positive codes 8 and above the negative input is chosen automatically.
// R10: Reserved bits 12:5 of the step-zero configuration always read zero.
// R11: Writing the start control aborts a running sequence and restarts it.
// R12: Settings act on the next conversion and read back as last written.
//
// The AXI4-Lite register port was chosen for this implementation.
`timescale 1ns/1ns
module aacs_top (
    input  wire logic                              aclk,
    input  wire logic                              aresetn,
    input  wire logic [aacs_pkg::AXI_ADDR_W-1:0]   s_axi_awaddr,
    input  wire logic [2:0]                        s_axi_awprot,
    input  wire logic                              s_axi_awvalid,
    output logic                                   s_axi_awready,
    input  wire logic [aacs_pkg::AXI_DATA_W-1:0]   s_axi_wdata,
    input  wire logic [3:0]                        s_axi_wstrb,
    input  wire logic                              s_axi_wvalid,
    output logic                                   s_axi_wready,
    output logic [1:0]                             s_axi_bresp,
    output logic                                   s_axi_bvalid,
    input  wire logic                              s_axi_bready,
    input  wire logic [aacs_pkg::AXI_ADDR_W-1:0]   s_axi_araddr,
    input  wire logic [2:0]                        s_axi_arprot,
    input  wire logic                              s_axi_arvalid,
    output logic                                   s_axi_arready,
    output logic [aacs_pkg::AXI_DATA_W-1:0]        s_axi_rdata,
    output logic [1:0]                             s_axi_rresp,
    output logic                                   s_axi_rvalid,
    input  wire logic                              s_axi_rready,
    input  wire logic [15:0]                       raw_result,
    input  wire logic                              raw_valid,
    output logic [15:0]                            corrected_result,
    output logic                                   corrected_valid,
    output logic                                   step_zero_convert,
    output logic [2:0]                             aux_gain_setting,
    output logic [3:0]                             step_zero_positive_select,
    output logic                                   step_zero_negative_select,
    output logic                                   negative_auto_select,
    output logic                                   sequence_restart
);

    // ******************************************************
    // State
    // ******************************************************
    typedef struct packed {
        logic                            aw_got;
        logic [aacs_pkg::AXI_ADDR_W-1:0] aw_addr;
        logic                            w_got;
        logic [aacs_pkg::AXI_DATA_W-1:0] w_data;
        logic [3:0]                      w_strb;
        logic                            b_valid;
        logic [1:0]                      b_resp;
        logic                            r_valid;
        logic [aacs_pkg::AXI_DATA_W-1:0] r_data;
        logic [1:0]                      r_resp;
        logic [15:0]                     ocal;
        logic [15:0]                     gcal;
        logic [15:0]                     step_cfg;
        logic                            restart;
        logic                            res_valid;
        logic [15:0]                     res_data;
    } aacs_state_t;

    aacs_state_t                     s_q;
    aacs_state_t                     s_d;
    logic                            aw_fire;
    logic                            w_fire;
    logic                            ar_fire;
    logic                            do_write;
    logic [aacs_pkg::AXI_ADDR_W-1:0] wr_addr;
    logic [aacs_pkg::AXI_DATA_W-1:0] wr_data;
    logic [3:0]                      wr_strb;
    logic signed [17:0]              off_s;
    logic signed [17:0]              x_s;
    logic signed [33:0]              prod_s;
    logic signed [18:0]              sum_s;

    // Byte lanes 0 and 1 carry the 16-bit registers; upper lanes are ignored
    function automatic logic [15:0] merge16(input logic [15:0] old_v,
                                            input logic [31:0] data,
                                            input logic [3:0]  strb);
        logic [15:0] r;
        r = old_v;
        if (strb[0]) begin
            r[7:0] = data[7:0];
        end
        if (strb[1]) begin
            r[15:8] = data[15:8];
        end
        return r;
    endfunction : merge16

    // ******************************************************
    // Bus handshakes
    // ******************************************************
    // No new write is accepted while a response waits; keeps one write in flight
    assign s_axi_awready = ~s_q.aw_got & ~s_q.b_valid;
    assign s_axi_wready  = ~s_q.w_got & ~s_q.b_valid;
    assign s_axi_arready = ~s_q.r_valid;
    assign aw_fire       = s_axi_awvalid & s_axi_awready;
    assign w_fire        = s_axi_wvalid & s_axi_wready;
    assign ar_fire       = s_axi_arvalid & s_axi_arready;
    assign wr_addr       = s_q.aw_got ? s_q.aw_addr : s_axi_awaddr;
    assign wr_data       = s_q.w_got ? s_q.w_data : s_axi_wdata;
    assign wr_strb       = s_q.w_got ? s_q.w_strb : s_axi_wstrb;
    assign do_write      = (s_q.aw_got | aw_fire) & (s_q.w_got | w_fire);

    // ******************************************************
    // Correction datapath
    // ******************************************************
    always_comb begin
        // Finer offset weight at raised gain
        if (s_q.step_cfg[aacs_pkg::STEP_GAIN_MSB:aacs_pkg::STEP_GAIN_LSB]
                == aacs_pkg::GAIN_CODE_1) begin
            off_s = 18'(signed'(s_q.ocal)); // R2
        end else begin
            off_s = 18'(signed'(s_q.ocal) >>> 1); // R2
        end
        x_s    = 18'(signed'(raw_result)) + off_s; // R1
        prod_s = 34'(x_s * signed'(s_q.gcal)); // R3
        sum_s  = 19'(x_s) + 19'(prod_s >>> aacs_pkg::GCAL_FRAC_BITS); // R3
    end

    // ******************************************************
    // Next state
    // ******************************************************
    always_comb begin
        s_d         = s_q;
        s_d.restart = 1'b0;
        if (aw_fire) begin
            s_d.aw_got  = 1'b1;
            s_d.aw_addr = s_axi_awaddr;
        end
        if (w_fire) begin
            s_d.w_got  = 1'b1;
            s_d.w_data = s_axi_wdata;
            s_d.w_strb = s_axi_wstrb;
        end
        if (s_q.b_valid && s_axi_bready) begin
            s_d.b_valid = 1'b0;
        end
        if (do_write) begin
            s_d.aw_got  = 1'b0;
            s_d.w_got   = 1'b0;
            s_d.b_valid = 1'b1;
            s_d.b_resp  = aacs_pkg::RESP_OKAY;
            case (wr_addr)
                aacs_pkg::AUX_OFFSET_CORRECTION_ADDR: begin
                    s_d.ocal = merge16(s_q.ocal, wr_data, wr_strb); // R12
                end
                aacs_pkg::AUX_GAIN_CORRECTION_ADDR: begin
                    s_d.gcal = merge16(s_q.gcal, wr_data, wr_strb); // R12
                end
                aacs_pkg::SEQUENCE_STEP_ZERO_CONFIG_ADDR: begin
                    // Reserved bits never stored
                    s_d.step_cfg = merge16(s_q.step_cfg, wr_data, wr_strb)
                                   & aacs_pkg::STEP_CFG_WMASK; // R10
                end
                aacs_pkg::AUX_SEQUENCE_CONTROL_ADDR: begin
                    s_d.restart = wr_strb[0] & wr_data[aacs_pkg::SEQ_START_BIT]; // R11
                end
                aacs_pkg::AUX_RESULT_STATUS_ADDR: begin
                    s_d.b_resp = aacs_pkg::RESP_OKAY;
                end
                default: begin
                    s_d.b_resp = aacs_pkg::RESP_SLVERR;
                end
            endcase
        end
        if (s_q.r_valid && s_axi_rready) begin
            s_d.r_valid = 1'b0;
        end
        if (ar_fire) begin
            s_d.r_valid = 1'b1;
            s_d.r_resp  = aacs_pkg::RESP_OKAY;
            s_d.r_data  = '0;
            case (s_axi_araddr)
                aacs_pkg::AUX_OFFSET_CORRECTION_ADDR: begin
                    s_d.r_data[15:0] = s_q.ocal;
                end
                aacs_pkg::AUX_GAIN_CORRECTION_ADDR: begin
                    s_d.r_data[15:0] = s_q.gcal;
                end
                aacs_pkg::SEQUENCE_STEP_ZERO_CONFIG_ADDR: begin
                    s_d.r_data[15:0] = s_q.step_cfg;
                end
                aacs_pkg::AUX_SEQUENCE_CONTROL_ADDR: begin
                    s_d.r_data[15:0] = 16'h0000;
                end
                aacs_pkg::AUX_RESULT_STATUS_ADDR: begin
                    s_d.r_data[15:0] = s_q.res_data;
                end
                default: begin
                    s_d.r_resp = aacs_pkg::RESP_SLVERR;
                end
            endcase
        end
        // Settings sampled in the same cycle as the raw result
        s_d.res_valid = raw_valid; // R12
        if (raw_valid) begin
            if (sum_s > 19'sd32767) begin
                s_d.res_data = 16'h7fff;
            end else if (sum_s < -19'sd32768) begin
                s_d.res_data = 16'h8000;
            end else begin
                s_d.res_data = sum_s[15:0]; // R1
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_q          <= '0;
            s_q.ocal     <= aacs_pkg::AUX_OFFSET_CORRECTION_RST;
            s_q.gcal     <= aacs_pkg::AUX_GAIN_CORRECTION_RST;
            s_q.step_cfg <= aacs_pkg::SEQUENCE_STEP_ZERO_CONFIG_RST;
        end else begin
            s_q <= s_d;
        end
    end

    // ******************************************************
    // Outputs
    // ******************************************************
    assign s_axi_bvalid     = s_q.b_valid;
    assign s_axi_bresp      = s_q.b_resp;
    assign s_axi_rvalid     = s_q.r_valid;
    assign s_axi_rdata      = s_q.r_data;
    assign s_axi_rresp      = s_q.r_resp;
    assign corrected_result = s_q.res_data;
    assign corrected_valid  = s_q.res_valid;
    assign sequence_restart = s_q.restart; // R11
    assign step_zero_convert = s_q.step_cfg[aacs_pkg::STEP_ENABLE_BIT]; // R4
    assign step_zero_positive_select = s_q.step_cfg[aacs_pkg::STEP_POS_MSB:0]; // R7 R8
    assign negative_auto_select =
        (s_q.step_cfg[aacs_pkg::STEP_POS_MSB:0] >= aacs_pkg::POS_AUTO_NEG_FIRST); // R9
    // Select bit ignored under automatic choice
    assign step_zero_negative_select =
        s_q.step_cfg[aacs_pkg::STEP_NEG_BIT] & ~negative_auto_select; // R6 R9

    always_comb begin
        case (s_q.step_cfg[aacs_pkg::STEP_GAIN_MSB:aacs_pkg::STEP_GAIN_LSB])
            aacs_pkg::GAIN_CODE_1: aux_gain_setting = aacs_pkg::GAIN_VAL_1; // R5
            aacs_pkg::GAIN_CODE_2: aux_gain_setting = aacs_pkg::GAIN_VAL_2; // R5
            default:               aux_gain_setting = aacs_pkg::GAIN_VAL_4; // R5
        endcase
    end

    // ******************************************************
    // Assertions
    // ******************************************************
    sequence seq_start_write;
        do_write && (wr_addr == aacs_pkg::AUX_SEQUENCE_CONTROL_ADDR)
            && wr_strb[0] && wr_data[0];
    endsequence

    sequence seq_one_pulse;
        sequence_restart ##1 !sequence_restart;
    endsequence

    a_start_pulse: assert property (@(posedge aclk) disable iff (!aresetn) // R11
        seq_start_write |=> seq_one_pulse)
        else $error("start write did not give one restart pulse");

    a_offset_readback: assert property (@(posedge aclk) disable iff (!aresetn) // R12
        (do_write && wr_addr == aacs_pkg::AUX_OFFSET_CORRECTION_ADDR && wr_strb[1:0] == 2'b11)
        |=> (s_q.ocal == $past(wr_data[15:0])))
        else $error("offset word not stored as written");

    a_reserved_zero: assert property (@(posedge aclk) disable iff (!aresetn) // R10
        s_axi_rvalid && $past(s_axi_araddr == aacs_pkg::SEQUENCE_STEP_ZERO_CONFIG_ADDR
            && ar_fire) |-> (s_axi_rdata[12:5] == 8'h00))
        else $error("reserved config bits read nonzero");

    a_gain_decode: assert property (@(posedge aclk) disable iff (!aresetn) // R5
        aux_gain_setting == (s_q.step_cfg[14:13] == 2'b00 ? 3'h1 :
                             s_q.step_cfg[14:13] == 2'b01 ? 3'h2 : 3'h4))
        else $error("gain setting does not match gain code");

    a_neg_auto: assert property (@(posedge aclk) disable iff (!aresetn) // R9
        s_q.step_cfg[3] |-> (negative_auto_select && !step_zero_negative_select))
        else $error("negative select not ignored for internal source");

    a_neg_manual: assert property (@(posedge aclk) disable iff (!aresetn) // R6
        !s_q.step_cfg[3] |-> (step_zero_negative_select == s_q.step_cfg[4]))
        else $error("negative select does not follow bit 4");

    a_step_enable: assert property (@(posedge aclk) disable iff (!aresetn) // R4
        (do_write && wr_addr == aacs_pkg::SEQUENCE_STEP_ZERO_CONFIG_ADDR && wr_strb[1])
        |=> (step_zero_convert == $past(wr_data[15])))
        else $error("step enable does not follow written bit");

    a_pos_route: assert property (@(posedge aclk) disable iff (!aresetn) // R7
        (do_write && wr_addr == aacs_pkg::SEQUENCE_STEP_ZERO_CONFIG_ADDR && wr_strb[0])
        |=> (step_zero_positive_select == $past(wr_data[3:0])))
        else $error("positive select does not follow written code");

    a_identity_corr: assert property (@(posedge aclk) disable iff (!aresetn) // R3
        (raw_valid && s_q.ocal == 16'h0000 && s_q.gcal == 16'h0000)
        |=> (corrected_valid && corrected_result == $past(raw_result)))
        else $error("zero corrections changed the result");

    a_half_offset: assert property (@(posedge aclk) disable iff (!aresetn) // R2
        (raw_valid && raw_result == 16'h0000 && s_q.gcal == 16'h0000
            && s_q.step_cfg[14:13] != 2'b00 && s_q.ocal == 16'h0010)
        |=> (corrected_result == 16'h0008))
        else $error("offset not halved at raised gain");

    a_full_offset: assert property (@(posedge aclk) disable iff (!aresetn) // R1
        (raw_valid && raw_result == 16'h0100 && s_q.gcal == 16'h0000
            && s_q.step_cfg[14:13] == 2'b00 && s_q.ocal == 16'hfff0)
        |=> (corrected_result == 16'h00f0))
        else $error("signed offset not applied at gain one");

    a_write_resp: assert property (@(posedge aclk) disable iff (!aresetn) // R12
        do_write |=> (s_axi_bvalid && !s_axi_awready && !s_axi_wready))
        else $error("write response missing one cycle after write");

endmodule : aacs_top

// File: test/tb_top.sv
// Self-checking bench for the auxiliary converter calibration and step-zero register block.
// Assumes the design answers AXI4-Lite within a few cycles and uses aclk for results too.
`timescale 1ns/1ns
module tb_top;
    // ******************************************************
    // Stimulus signals and design instance
    // ******************************************************
    localparam logic [11:0] off_a  = aacs_pkg::AUX_OFFSET_CORRECTION_ADDR;
    localparam logic [11:0] gain_a = aacs_pkg::AUX_GAIN_CORRECTION_ADDR;
    localparam logic [11:0] cfg_a  = aacs_pkg::SEQUENCE_STEP_ZERO_CONFIG_ADDR;
    localparam logic [1:0]  ok     = aacs_pkg::RESP_OKAY;
    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
    logic [2:0]  s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, raw_valid = 1'b0;
    logic [31:0] s_axi_wdata = 32'h0000_0000;
    logic [3:0]  s_axi_wstrb = 4'h0;
    logic [15:0] raw_result = 16'h0000;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic        corrected_valid, step_zero_convert, step_zero_negative_select;
    logic        negative_auto_select, sequence_restart;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    logic [15:0] corrected_result;
    logic [2:0]  aux_gain_setting;
    logic [3:0]  step_zero_positive_select;
    int          bad_count = 0, cmp_count = 0, restart_count = 0, base;

    always #5 aclk = ~aclk;
    // Counts high cycles, so a stretched pulse shows as a miscount
    always @(posedge aclk) if (sequence_restart === 1'b1) restart_count++;

    aacs_top i_aacs_top (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .raw_result, .raw_valid, .corrected_result, .corrected_valid,
        .step_zero_convert, .aux_gain_setting, .step_zero_positive_select,
        .step_zero_negative_select, .negative_auto_select, .sequence_restart);

    // ******************************************************
    // Checking and bus tasks
    // ******************************************************
    task automatic give_verdict();
        $display("Comparisons %0d, mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : give_verdict

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR t=%0t %s got %h expected %h", $time, msg, got, exp);
        end
    endtask : chk

    task automatic tick_limit(inout int n);
        n++;
        if (n > 50) begin
            bad_count++;
            $display("ERROR t=%0t bus wait ran out", $time);
            give_verdict();
        end
    endtask : tick_limit

    task automatic axi_write(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
        int   n;
        logic aw_done, w_done;
        n = 0;
        aw_done = 1'b0;
        w_done = 1'b0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= d;
        s_axi_wstrb <= 4'hf;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!(aw_done && w_done)) begin
            @(negedge aclk);
            aw_done = aw_done || (s_axi_awready === 1'b1);
            w_done = w_done || (s_axi_wready === 1'b1);
            @(posedge aclk);
            if (aw_done) s_axi_awvalid <= 1'b0;
            if (w_done) s_axi_wvalid <= 1'b0;
            tick_limit(n);
        end
        while (s_axi_bvalid !== 1'b1) begin
            @(negedge aclk);
            tick_limit(n);
        end
        chk(32'(s_axi_bresp), 32'(er), "write response");
        @(posedge aclk);
        s_axi_bready <= 1'b0;
    endtask : axi_write

    task automatic axi_read(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
        int n;
        n = 0;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(negedge aclk);
            tick_limit(n);
        end while (s_axi_arready !== 1'b1);
        @(posedge aclk);
        s_axi_arvalid <= 1'b0;
        while (s_axi_rvalid !== 1'b1) begin
            @(negedge aclk);
            tick_limit(n);
        end
        chk(s_axi_rdata, ed, "read data");
        chk(32'(s_axi_rresp), 32'(er), "read response");
        @(posedge aclk);
        s_axi_rready <= 1'b0;
    endtask : axi_read

    task automatic send_raw(input logic [15:0] x, input logic [15:0] exp);
        @(posedge aclk);
        raw_result <= x;
        raw_valid <= 1'b1;
        @(posedge aclk);
        raw_valid <= 1'b0;
        @(negedge aclk);
        chk(32'(corrected_valid), 32'h0000_0001, "result valid");
        chk(32'(corrected_result), 32'(exp), "corrected result");
    endtask : send_raw

    // ******************************************************
    // Scenarios
    // ******************************************************
    initial begin
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        axi_read(off_a, 32'h0000_0000, ok);
        axi_read(gain_a, 32'h0000_0000, ok);
        axi_read(cfg_a, 32'h0000_0000, ok);
        axi_write(off_a, 32'h0000_9234, ok);
        axi_read(off_a, 32'h0000_9234, ok);
        axi_write(gain_a, 32'h0000_abcd, ok);
        axi_read(gain_a, 32'h0000_abcd, ok);
        axi_write(cfg_a, 32'h0000_ffff, ok);
        axi_read(cfg_a, 32'h0000_e01f, ok);
        axi_write(12'h010, 32'h0000_0001, aacs_pkg::RESP_SLVERR);
        axi_read(12'h010, 32'h0000_0000, aacs_pkg::RESP_SLVERR);
        for (int g = 0; g < 4; g++) begin
            axi_write(cfg_a, 32'h0000_8000 | 32'(g << 13), ok);
            @(negedge aclk);
            chk(32'(step_zero_convert), 32'h0000_0001, "step enable");
            chk(32'(aux_gain_setting), (g == 0) ? 1 : (g == 1) ? 2 : 4, "gain");
        end
        for (int p = 0; p < 16; p++) begin
            axi_write(cfg_a, 32'h0000_0010 | 32'(p), ok);
            @(negedge aclk);
            chk(32'(step_zero_positive_select), 32'(p), "positive select");
            chk(32'(negative_auto_select), 32'(p >= 8), "auto negative");
            chk(32'(step_zero_negative_select), 32'(p < 8), "negative select");
        end
        axi_write(cfg_a, 32'h0000_0003, ok);
        @(negedge aclk);
        chk(32'(step_zero_convert), 32'h0000_0000, "step disable");
        chk(32'(step_zero_negative_select), 32'h0000_0000, "ground negative");
        // Offset alone: gain word zero, then halved offset weight at gain 2 and 4
        axi_write(gain_a, 32'h0000_0000, ok);
        axi_write(off_a, 32'h0000_0005, ok);
        send_raw(16'h0064, 16'h0069);
        axi_write(off_a, 32'h0000_fff0, ok);
        send_raw(16'h0100, 16'h00f0);
        axi_write(off_a, 32'h0000_fffc, ok);
        send_raw(16'h0064, 16'h0060);
        axi_write(cfg_a, 32'h0000_2000, ok);
        send_raw(16'h0064, 16'h0062);
        axi_write(off_a, 32'h0000_0007, ok);
        axi_write(cfg_a, 32'h0000_4000, ok);
        send_raw(16'h0064, 16'h0067);
        axi_write(off_a, 32'h0000_0010, ok);
        send_raw(16'h0000, 16'h0008);
        // Gain word extremes, including saturation both ways
        axi_write(off_a, 32'h0000_0000, ok);
        send_raw(16'h0064, 16'h0064);
        axi_write(gain_a, 32'h0000_8000, ok);
        send_raw(16'h03e8, 16'h01f4);
        send_raw(16'hfc18, 16'hfe0c);
        axi_write(gain_a, 32'h0000_7fff, ok);
        send_raw(16'h03e8, 16'h05db);
        send_raw(16'h7000, 16'h7fff);
        send_raw(16'h9000, 16'h8000);
        base = restart_count;
        axi_write(aacs_pkg::AUX_SEQUENCE_CONTROL_ADDR, 32'h0000_0001, ok);
        repeat (3) @(posedge aclk);
        chk(32'(restart_count - base), 32'h0000_0001, "restart pulse");
        // Status holds the last corrected result; writes there are ignored
        axi_write(aacs_pkg::AUX_RESULT_STATUS_ADDR, 32'h0000_1234, ok);
        axi_read(aacs_pkg::AUX_RESULT_STATUS_ADDR, 32'h0000_8000, ok);
        axi_read(aacs_pkg::AUX_SEQUENCE_CONTROL_ADDR, 32'h0000_0000, ok);
        give_verdict();
    end
endmodule : tb_top
